// [dv/rtcev_tb.sv]
// self-checking bench for the calendar event block
`timescale 1ns/10ps
module testbench;
  import rtcev_pkg::*;
  logic              core_clk_i;
  logic              auto_clear_on_read_n_i;
  rtcev_req_t        req_i;
  logic [7:0]        rdata_o;
  logic              tick_i;
  rtcev_cal_t        cal_i;
  logic              on_battery_i;
  logic [5:0]        fin_analog_trim_i;
  logic [2:0]        fin_digital_trim_i;
  logic              auto_clear_on_read_i;
  logic              freq_out_en_i;
  logic              irq_n_o;
  logic              hour_load_o;
  logic [7:0]        hour_value_o;
  logic signed [8:0] trim_ppm_o;
  int                errors;
  int                compares;
  int                lows;
  int                loads;
  logic [7:0]        hv;
  logic [7:0]        dst_def [8] = '{8'h04, 8'h80, 8'h01, 8'h02, 8'h10, 8'h80, 8'h01, 8'h02};

  rtcev_core u_rtcev_core (
    .core_clk_i           (core_clk_i),
    .auto_clear_on_read_n_i             (auto_clear_on_read_n_i),
    .req_i                (req_i),
    .rdata_o              (rdata_o),
    .tick_i               (tick_i),
    .cal_i                (cal_i),
    .on_battery_i         (on_battery_i),
    .fin_analog_trim_i    (fin_analog_trim_i),
    .fin_digital_trim_i   (fin_digital_trim_i),
    .auto_clear_on_read_i (auto_clear_on_read_i),
    .freq_out_en_i        (freq_out_en_i),
    .irq_n_o              (irq_n_o),
    .hour_load_o          (hour_load_o),
    .hour_value_o         (hour_value_o),
    .trim_ppm_o           (trim_ppm_o)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk_i);
    req_i = '0;
  endtask

  // read data is taken two edges on, since it holds until the next read
  task automatic chk_rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk_i);
    req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge core_clk_i);
    req_i = '0;
    @(negedge core_clk_i);
    chk(what, {8'h00, rdata_o}, {8'h00, exp});
  endtask

  task automatic chk_stamp(input logic [7:0] base, input rtcev_stamp_t exp);
    for (int i = 0; i < 5; i++) begin
      chk_rd("stamp byte", base + 8'(i), exp[39-8*i -: 8]);
    end
  endtask

  // tick is a level from the calendar; the window covers the sync delay
  task automatic do_tick(input rtcev_cal_t c);
    cal_i = c;
    lows = 0;
    loads = 0;
    hv = 8'h00;
    @(negedge core_clk_i);
    tick_i = 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(negedge core_clk_i);
      if (i == 3) begin
        tick_i = 1'b0;
      end
      if (irq_n_o === 1'b0) begin
        lows++;
      end
      if (hour_load_o === 1'b1) begin
        loads++;
        hv = hour_value_o;
      end
    end
  endtask

  task automatic power(input logic b, input rtcev_cal_t c);
    cal_i = c;
    on_battery_i = b;
    repeat (8) @(negedge core_clk_i);
  endtask

  task automatic sc_defaults();
    for (int i = 0; i < 8; i++) begin
      chk_rd("dst default", 8'h20 + 8'(i), dst_def[i]);
    end
    chk_stamp(8'h16, '0);
    chk_stamp(8'h1b, '0);
    chk_rd("unmapped", 8'h30, 8'h00);
  endtask

  task automatic sc_trim();
    logic signed [8:0] e;
    fin_analog_trim_i = 6'h2a;
    chk_rd("analog trim", 8'h0e, 8'h2a);
    reg_wr(8'h0e, 8'h15);
    chk_rd("analog trim kept", 8'h0e, 8'h2a);
    for (int c = 0; c < 8; c++) begin
      fin_digital_trim_i = 3'(c);
      e = (c < 6) ? 9'(32 * c) : (c == 6) ? 9'sd196 : -9'sd32;
      repeat (2) @(negedge core_clk_i);
      chk("trim ppm", {7'h00, trim_ppm_o}, {7'h00, e});
      reg_wr(8'h0f, 8'h00);
      chk_rd("digital trim", 8'h0f, 8'(c));
    end
  endtask

  task automatic sc_single();
    reg_wr(8'h10, 8'h30);
    do_tick({8'h30, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00});
    chk("no enable no fire", 16'(lows), 16'h0000);
    reg_wr(8'h10, 8'hb0);
    reg_wr(8'h11, 8'h85);
    chk_rd("alarm byte", 8'h11, 8'h85);
    do_tick({8'h30, 8'h04, 8'h01, 8'h01, 8'h01, 8'h00});
    chk("partial match", 16'(lows), 16'h0000);
    do_tick({8'h30, 8'h05, 8'h01, 8'h01, 8'h01, 8'h00});
    chk("single irq", {15'h0000, irq_n_o}, 16'h0000);
    chk_rd("flag set", 8'h08, 8'h01);
    chk("irq held", {15'h0000, irq_n_o}, 16'h0000);
    // the frequency output owns the pin, so the interrupt must let go
    freq_out_en_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk("freq masks irq", {15'h0000, irq_n_o}, 16'h0001);
    freq_out_en_i = 1'b0;
    reg_wr(8'h08, 8'h00);
    repeat (2) @(negedge core_clk_i);
    chk("irq released", {15'h0000, irq_n_o}, 16'h0001);
    chk_rd("flag cleared", 8'h08, 8'h00);
    reg_wr(8'h11, 8'h00);
  endtask

  task automatic sc_auto_clear();
    auto_clear_on_read_i = 1'b1;
    do_tick({8'h30, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00});
    chk_rd("flag before read", 8'h08, 8'h01);
    chk_rd("flag after read", 8'h08, 8'h00);
    chk("irq after read", {15'h0000, irq_n_o}, 16'h0001);
    auto_clear_on_read_i = 1'b0;
  endtask

  task automatic sc_pulsed();
    reg_wr(8'h09, 8'h40);
    for (int k = 0; k < 2; k++) begin
      do_tick({8'h30, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00});
      chk("pulse width", 16'(lows), 16'h0001);
      chk_rd("pulsed flag", 8'h08, 8'h01);
    end
    reg_wr(8'h09, 8'h00);
    reg_wr(8'h08, 8'h00);
    reg_wr(8'h10, 8'h00);
  endtask

  task automatic sc_stamps();
    rtcev_cal_t a;
    rtcev_cal_t d;
    a = {8'h11, 8'h22, 8'h13, 8'h14, 8'h05, 8'h02};
    d = {8'h41, 8'h52, 8'h23, 8'h28, 8'h12, 8'h04};
    power(1'b1, a);
    power(1'b0, {8'h12, 8'h23, 8'h14, 8'h15, 8'h06, 8'h03});
    power(1'b1, {8'h33, 8'h44, 8'h15, 8'h16, 8'h07, 8'h04});
    power(1'b0, d);
    chk_stamp(8'h16, a[47:8]);
    chk_stamp(8'h1b, d[47:8]);
    reg_wr(8'h16, 8'hff);
    chk_rd("stamp not writable", 8'h16, a[47:40]);
    reg_wr(8'h09, 8'h01);
    repeat (2) @(negedge core_clk_i);
    chk_stamp(8'h16, '0);
    chk_stamp(8'h1b, '0);
  endtask

  task automatic sc_dst();
    reg_wr(8'h20, 8'h84);
    reg_wr(8'h21, 8'h00);
    do_tick({8'h00, 8'h00, 8'h02, 8'h02, 8'h04, 8'h00});
    chk("wrong date", 16'(loads), 16'h0000);
    do_tick({8'h00, 8'h00, 8'h02, 8'h01, 8'h04, 8'h03});
    chk("forward load", 16'(loads), 16'h0001);
    chk("forward hour", {8'h00, hv}, 16'h0003);
    do_tick({8'h00, 8'h00, 8'h02, 8'h01, 8'h10, 8'h00});
    chk("reverse load", 16'(loads), 16'h0001);
    chk("reverse hour", {8'h00, hv}, 16'h0001);
    // the repeated hour must not be set back a second time
    do_tick({8'h00, 8'h00, 8'h02, 8'h01, 8'h10, 8'h00});
    chk("one set-back", 16'(loads), 16'h0000);
    do_tick({8'h01, 8'h00, 8'h02, 8'h01, 8'h10, 8'h00});
    reg_wr(8'h23, 8'h82);
    do_tick({8'h00, 8'h00, 8'h02, 8'h01, 8'h04, 8'h03});
    chk("format mismatch", 16'(loads), 16'h0000);
    do_tick({8'h00, 8'h00, 8'h82, 8'h01, 8'h04, 8'h03});
    chk("24h forward load", 16'(loads), 16'h0001);
    chk("24h forward hour", {8'h00, hv}, 16'h0083);
  endtask

  initial begin
    errors = 0;
    compares = 0;
    auto_clear_on_read_n_i = 1'b0;
    req_i = '0;
    tick_i = 1'b0;
    cal_i = {8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
    on_battery_i = 1'b0;
    fin_analog_trim_i = 6'h00;
    fin_digital_trim_i = 3'h0;
    auto_clear_on_read_i = 1'b0;
    freq_out_en_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    auto_clear_on_read_n_i = 1'b1;
    chk("irq idle", {15'h0000, irq_n_o}, 16'h0001);
    sc_defaults();
    sc_trim();
    sc_single();
    sc_auto_clear();
    sc_pulsed();
    sc_stamps();
    sc_dst();
    give_verdict();
  end
endmodule

// [rtl/rtcev_core.sv]
// alarm, time stamp, trim readback and daylight-saving control
`timescale 1ns/10ps
`include "rtcev_params.svh"
module rtcev_core
  import rtcev_pkg::*;
(
  input  wire logic         core_clk_i,
  input  wire logic         auto_clear_on_read_n_i,
  input  wire rtcev_req_t   req_i,
  output logic [7:0]        rdata_o,
  input  wire logic         tick_i,
  input  wire rtcev_cal_t   cal_i,
  input  wire logic         on_battery_i,
  input  wire logic [5:0]   fin_analog_trim_i,
  input  wire logic [2:0]   fin_digital_trim_i,
  input  wire logic         auto_clear_on_read_i,
  input  wire logic         freq_out_en_i,
  output logic              irq_n_o,
  output logic              hour_load_o,
  output logic [7:0]        hour_value_o,
  output logic signed [8:0] trim_ppm_o
);
  logic [7:0]   alarm_reg [0:5];
  logic [7:0]   dst_reg   [0:7];
  logic         alarm_flag;
  logic         interrupt_mode_bit;
  rtcev_stamp_t supply_to_battery_stamp;
  rtcev_stamp_t battery_to_supply_stamp;
  logic         batt_meta;
  logic         batt_sync;
  logic         batt_prev;
  logic         tick_meta;
  logic         tick_sync;
  logic         tick_prev;
  rtcev_dst_t   dst_state;
  logic [7:0]   cal_byte [0:5];
  logic [5:0]   field_hit;
  logic         alarm_match;
  logic         tick_evt;
  logic         v2b_evt;
  logic         b2v_evt;
  logic         stamp_clr;
  logic         wr_alarm_flag;
  logic         next_pulse;
  logic         pulse_q;
  logic         dst_fwd_hit;
  logic         dst_rev_hit;

  function automatic logic day_hit(input logic [7:0] dw, input logic [7:0] dt,
                                   input rtcev_cal_t c);
    // weekday priority picks by day of week, else by date
    day_hit = dw[`RTCEV_BIT_MSB] ? (c.wday[2:0] == dw[2:0])
                                 : (c.date == {2'b00, dt[5:0]});
  endfunction

  assign cal_byte = '{cal_i.sec, cal_i.min, cal_i.hour,
                      cal_i.date, cal_i.month, cal_i.wday};

  // bit 7 enables the field; the remaining bits compare like the calendar byte
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_cmp
      assign field_hit[gi] = !alarm_reg[gi][`RTCEV_BIT_MSB] ||
        (alarm_reg[gi][6:0] == cal_byte[gi][6:0]);
    end
  endgenerate

  // nothing enabled never fires
  assign alarm_match = (&field_hit) &&
    (|{alarm_reg[0][7], alarm_reg[1][7], alarm_reg[2][7],
       alarm_reg[3][7], alarm_reg[4][7], alarm_reg[5][7]});

  // the battery pin and the tick come from outside, so they are synchronised first
  always_ff @(posedge core_clk_i or negedge auto_clear_on_read_n_i) begin
    if (!auto_clear_on_read_n_i) begin
      batt_meta <= 1'b0;
      batt_sync <= 1'b0;
      batt_prev <= 1'b0;
      tick_meta <= 1'b0;
      tick_sync <= 1'b0;
      tick_prev <= 1'b0;
    end else begin
      batt_meta <= on_battery_i;
      batt_sync <= batt_meta;
      batt_prev <= batt_sync;
      tick_meta <= tick_i;
      tick_sync <= tick_meta;
      tick_prev <= tick_sync;
    end
  end

  assign tick_evt  = tick_sync && !tick_prev;
  assign v2b_evt   = batt_sync && !batt_prev;
  assign b2v_evt   = !batt_sync && batt_prev;
  assign stamp_clr = req_i.wr && (req_i.addr == `RTCEV_A_PWR) &&
                     req_i.wdata[`RTCEV_BIT_STCLR];
  assign wr_alarm_flag = req_i.wr && (req_i.addr == `RTCEV_A_STATUS);

  // alarm and mode registers
  always_ff @(posedge core_clk_i or negedge auto_clear_on_read_n_i) begin
    if (!auto_clear_on_read_n_i) begin
      for (int i = 0; i < 6; i++) begin
        alarm_reg[i] <= `RTCEV_ZERO8;
      end
      interrupt_mode_bit <= 1'b0;
    end else if (req_i.wr) begin
      for (int i = 0; i < 6; i++) begin
        if (req_i.addr == `RTCEV_A_ALARM0 + 8'(i)) begin
          alarm_reg[i] <= req_i.wdata;
        end
      end
      if (req_i.addr == `RTCEV_A_PWR) begin
        interrupt_mode_bit <= req_i.wdata[`RTCEV_BIT_MODE];
      end
    end
  end

  // the flag: a match in the same cycle as a clear wins
  always_ff @(posedge core_clk_i or negedge auto_clear_on_read_n_i) begin
    if (!auto_clear_on_read_n_i) begin
      alarm_flag <= 1'b0;
    end else if (tick_evt && alarm_match) begin
      alarm_flag <= 1'b1;
    end else if (wr_alarm_flag && !req_i.wdata[`RTCEV_BIT_FLAG]) begin
      alarm_flag <= 1'b0;
    end else if (req_i.rd && (req_i.addr == `RTCEV_A_STATUS) && auto_clear_on_read_i) begin
      alarm_flag <= 1'b0;
    end
  end

  // pulsed mode gives one clock low per match and ignores the flag
  assign next_pulse = tick_evt && alarm_match && interrupt_mode_bit;

  always_ff @(posedge core_clk_i or negedge auto_clear_on_read_n_i) begin
    if (!auto_clear_on_read_n_i) begin
      pulse_q <= 1'b0;
      irq_n_o <= 1'b1;
    end else begin
      pulse_q <= next_pulse;
      if (freq_out_en_i) begin
        irq_n_o <= 1'b1;
      end else if (interrupt_mode_bit) begin
        irq_n_o <= !next_pulse;
      end else begin
        irq_n_o <= !((tick_evt && alarm_match) || alarm_flag);
      end
    end
  end

  // time stamps; a clear loses to a capture in the same cycle
  always_ff @(posedge core_clk_i or negedge auto_clear_on_read_n_i) begin
    if (!auto_clear_on_read_n_i) begin
      supply_to_battery_stamp <= '0;
      battery_to_supply_stamp <= '0;
    end else begin
      if (v2b_evt && ((supply_to_battery_stamp == '0) || stamp_clr)) begin
        supply_to_battery_stamp <= {cal_i.sec, cal_i.min, cal_i.hour,
                                    cal_i.date, cal_i.month};
      end else if (stamp_clr) begin
        supply_to_battery_stamp <= '0;
      end
      if (b2v_evt) begin
        battery_to_supply_stamp <= {cal_i.sec, cal_i.min, cal_i.hour,
                                    cal_i.date, cal_i.month};
      end else if (stamp_clr) begin
        battery_to_supply_stamp <= '0;
      end
    end
  end

  // daylight control bytes
  always_ff @(posedge core_clk_i or negedge auto_clear_on_read_n_i) begin
    if (!auto_clear_on_read_n_i) begin
      dst_reg[0] <= `RTCEV_DST_MO_F;
      dst_reg[1] <= `RTCEV_DST_DW_F;
      dst_reg[2] <= `RTCEV_DST_DT_F;
      dst_reg[3] <= `RTCEV_DST_HR_F;
      dst_reg[4] <= `RTCEV_DST_MO_R;
      dst_reg[5] <= `RTCEV_DST_DW_R;
      dst_reg[6] <= `RTCEV_DST_DT_R;
      dst_reg[7] <= `RTCEV_DST_HR_R;
    end else if (req_i.wr) begin
      for (int i = 0; i < 8; i++) begin
        if (req_i.addr == `RTCEV_A_DST0 + 8'(i)) begin
          dst_reg[i] <= req_i.wdata;
        end
      end
    end
  end

  // start and end points; the hour compare includes the format bit, so a
  // mismatched format never fires
  assign dst_fwd_hit = dst_reg[0][`RTCEV_BIT_MSB] &&
    (cal_i.month == {3'b000, dst_reg[0][4:0]}) &&
    day_hit(dst_reg[1], dst_reg[2], cal_i) &&
    (cal_i.hour == dst_reg[3]) && (cal_i.min == `RTCEV_ZERO8) &&
    (cal_i.sec == `RTCEV_ZERO8);
  assign dst_rev_hit = dst_reg[0][`RTCEV_BIT_MSB] &&
    (cal_i.month == {3'b000, dst_reg[4][4:0]}) &&
    day_hit(dst_reg[5], dst_reg[6], cal_i) &&
    (cal_i.hour == dst_reg[7]) && (cal_i.min == `RTCEV_ZERO8) &&
    (cal_i.sec == `RTCEV_ZERO8);

  function automatic logic [7:0] hour_step(input logic [7:0] h, input logic up);
    logic [7:0] r;
    r = h;
    if (!h[`RTCEV_BIT_MSB]) begin
      // twelve-hour BCD keeps the format and pm bits
      if (up) begin
        r[4:0] = (h[4:0] == 5'(`RTCEV_HR_TWELVE)) ? 5'(`RTCEV_HR_ONE) :
                 (h[4:0] == 5'(`RTCEV_HR_NINE)) ? 5'h10 : h[4:0] + 5'h01;
      end else begin
        r[4:0] = (h[4:0] == 5'(`RTCEV_HR_ONE)) ? 5'(`RTCEV_HR_TWELVE) :
                 (h[4:0] == 5'h10) ? 5'(`RTCEV_HR_NINE) : h[4:0] - 5'h01;
      end
    end else begin
      if (up) begin
        r[5:0] = (h[5:0] == 6'(`RTCEV_HR_TWTY3)) ? 6'(`RTCEV_HR_ZERO) :
                 (h[3:0] == 4'h9) ? {h[5:4] + 2'h1, 4'h0} : h[5:0] + 6'h01;
      end else begin
        r[5:0] = (h[5:0] == 6'(`RTCEV_HR_ZERO)) ? 6'(`RTCEV_HR_TWTY3) :
                 (h[3:0] == 4'h0) ? {h[5:4] - 2'h1, 4'h9} : h[5:0] - 6'h01;
      end
    end
    hour_step = r;
  endfunction

  // the wait state blocks a second set-back when the repeated hour comes round
  always_ff @(posedge core_clk_i or negedge auto_clear_on_read_n_i) begin
    if (!auto_clear_on_read_n_i) begin
      dst_state    <= RTCEV_DST_OFF;
      hour_load_o  <= 1'b0;
      hour_value_o <= `RTCEV_ZERO8;
    end else begin
      hour_load_o <= 1'b0;
      unique case (dst_state)
        RTCEV_DST_OFF: begin
          if (tick_evt && dst_fwd_hit) begin
            hour_load_o  <= 1'b1;
            hour_value_o <= hour_step(cal_i.hour, 1'b1);
            dst_state    <= RTCEV_DST_ON;
          end
        end
        RTCEV_DST_ON: begin
          if (tick_evt && dst_rev_hit) begin
            hour_load_o  <= 1'b1;
            hour_value_o <= hour_step(cal_i.hour, 1'b0);
            dst_state    <= RTCEV_DST_WAIT;
          end
        end
        RTCEV_DST_WAIT: begin
          if (tick_evt && (cal_i.hour == dst_reg[7]) && !dst_rev_hit) begin
            dst_state <= RTCEV_DST_OFF;
          end
        end
        default: dst_state <= RTCEV_DST_OFF;
      endcase
    end
  end

  // signed ppm value of the digital trim code
  always_ff @(posedge core_clk_i or negedge auto_clear_on_read_n_i) begin
    if (!auto_clear_on_read_n_i) begin
      trim_ppm_o <= 9'sh000;
    end else if (fin_digital_trim_i == `RTCEV_CODE_NEG) begin
      trim_ppm_o <= `RTCEV_PPM_NEG;
    end else if (fin_digital_trim_i == `RTCEV_CODE_SIX) begin
      trim_ppm_o <= `RTCEV_PPM_SIX;
    end else begin
      trim_ppm_o <= 9'(`RTCEV_PPM_STEP * $signed({6'h00, fin_digital_trim_i}));
    end
  end

  // read port; trim bytes have no write path at all
  always_ff @(posedge core_clk_i or negedge auto_clear_on_read_n_i) begin
    if (!auto_clear_on_read_n_i) begin
      rdata_o <= `RTCEV_ZERO8;
    end else if (req_i.rd) begin
      rdata_o <= `RTCEV_ZERO8;
      if (req_i.addr == `RTCEV_A_ANA_TRIM) begin
        rdata_o <= {2'b00, fin_analog_trim_i};
      end
      if (req_i.addr == `RTCEV_A_DIG_TRIM) begin
        rdata_o <= {5'h00, fin_digital_trim_i};
      end
      if (req_i.addr == `RTCEV_A_STATUS) begin
        rdata_o <= {7'h00, alarm_flag};
      end
      if (req_i.addr == `RTCEV_A_PWR) begin
        rdata_o <= {1'b0, interrupt_mode_bit, 6'h00};
      end
      for (int i = 0; i < 6; i++) begin
        if (req_i.addr == `RTCEV_A_ALARM0 + 8'(i)) begin
          rdata_o <= alarm_reg[i];
        end
      end
      for (int i = 0; i < 5; i++) begin
        if (req_i.addr == `RTCEV_A_V2B0 + 8'(i)) begin
          rdata_o <= supply_to_battery_stamp[39 - 8 * i -: 8];
        end
        if (req_i.addr == `RTCEV_A_B2V0 + 8'(i)) begin
          rdata_o <= battery_to_supply_stamp[39 - 8 * i -: 8];
        end
      end
      for (int i = 0; i < 8; i++) begin
        if (req_i.addr == `RTCEV_A_DST0 + 8'(i)) begin
          rdata_o <= dst_reg[i];
        end
      end
    end
  end

  property p_single_hold;
    @(posedge core_clk_i) disable iff (!auto_clear_on_read_n_i)
      (alarm_flag && !interrupt_mode_bit && !freq_out_en_i) |=> !irq_n_o;
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("irq not low");

  property p_pulse_one;
    @(posedge core_clk_i) disable iff (!auto_clear_on_read_n_i)
      (next_pulse && !freq_out_en_i) |=> !irq_n_o ##1 (irq_n_o || pulse_q);
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("pulse wrong");

  property p_flag_set;
    @(posedge core_clk_i) disable iff (!auto_clear_on_read_n_i)
      (tick_evt && alarm_match) |=> alarm_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_flag_clr;
    @(posedge core_clk_i) disable iff (!auto_clear_on_read_n_i)
      (wr_alarm_flag && !req_i.wdata[0] && !(tick_evt && alarm_match)) |=> !alarm_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  property p_v2b_first;
    @(posedge core_clk_i) disable iff (!auto_clear_on_read_n_i)
      (supply_to_battery_stamp != '0) && !stamp_clr |=> $stable(supply_to_battery_stamp);
  endproperty
  a_v2b_first: assert property (p_v2b_first) else $error("stamp overwritten");

  property p_clear;
    @(posedge core_clk_i) disable iff (!auto_clear_on_read_n_i)
      (stamp_clr && !b2v_evt && !v2b_evt) |=> (battery_to_supply_stamp == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("stamp not cleared");

  property p_fwd;
    @(posedge core_clk_i) disable iff (!auto_clear_on_read_n_i)
      (dst_state == RTCEV_DST_OFF && tick_evt && dst_fwd_hit) |=>
        hour_load_o ##1 !hour_load_o;
  endproperty
  a_fwd: assert property (p_fwd) else $error("no forward jump");

  property p_trim;
    @(posedge core_clk_i) disable iff (!auto_clear_on_read_n_i)
      (fin_digital_trim_i == 3'h7) |=> (trim_ppm_o == `RTCEV_PPM_NEG);
  endproperty
  a_trim: assert property (p_trim) else $error("trim ppm wrong");

  c_alarm: cover property (@(posedge core_clk_i) disable iff (!auto_clear_on_read_n_i)
    tick_evt && alarm_match);
  c_v2b: cover property (@(posedge core_clk_i) disable iff (!auto_clear_on_read_n_i) v2b_evt);
  c_rev: cover property (@(posedge core_clk_i) disable iff (!auto_clear_on_read_n_i)
    dst_state == RTCEV_DST_ON ##1 dst_state == RTCEV_DST_WAIT);
endmodule

// [rtl/rtcev_params.svh]
// constants for the calendar event block
`ifndef RTCEV_PARAMS_SVH
`define RTCEV_PARAMS_SVH
`define RTCEV_A_STATUS   8'h08
`define RTCEV_A_PWR      8'h09
`define RTCEV_A_ANA_TRIM 8'h0e
`define RTCEV_A_DIG_TRIM 8'h0f
`define RTCEV_A_ALARM0   8'h10
`define RTCEV_A_ALARM5   8'h15
`define RTCEV_A_V2B0     8'h16
`define RTCEV_A_V2B4     8'h1a
`define RTCEV_A_B2V0     8'h1b
`define RTCEV_A_B2V4     8'h1f
`define RTCEV_A_DST0     8'h20
`define RTCEV_A_DST7     8'h27
`define RTCEV_BIT_MSB    7
`define RTCEV_BIT_FLAG   0
`define RTCEV_BIT_MODE   6
`define RTCEV_BIT_STCLR  0
`define RTCEV_HR_PM      5
`define RTCEV_DST_MO_F   8'h04
`define RTCEV_DST_DW_F   8'h80
`define RTCEV_DST_DT_F   8'h01
`define RTCEV_DST_HR_F   8'h02
`define RTCEV_DST_MO_R   8'h10
`define RTCEV_DST_DW_R   8'h80
`define RTCEV_DST_DT_R   8'h01
`define RTCEV_DST_HR_R   8'h02
`define RTCEV_HR_ONE     8'h01
`define RTCEV_HR_TWELVE  8'h12
`define RTCEV_HR_NINE    8'h09
`define RTCEV_HR_NINETN  8'h19
`define RTCEV_HR_TWTY3   8'h23
`define RTCEV_HR_ZERO    8'h00
`define RTCEV_ZERO8      8'h00
`define RTCEV_PPM_STEP   9'sh020
`define RTCEV_PPM_SIX    9'sh0c4
`define RTCEV_PPM_NEG    9'sh1e0
`define RTCEV_CODE_SIX   3'h6
`define RTCEV_CODE_NEG   3'h7
`endif

// [rtl/rtcev_pkg.sv]
// types for the calendar event block
package rtcev_pkg;
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] wday;
  } rtcev_cal_t;
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] month;
  } rtcev_stamp_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtcev_req_t;
  typedef enum logic [1:0] {
    RTCEV_DST_OFF  = 2'b00,
    RTCEV_DST_WAIT = 2'b01,
    RTCEV_DST_ON   = 2'b10
  } rtcev_dst_t;
endpackage
